// ===== common/fpu_pkg.sv
/*
  Constants, field layouts and carrier types shared by the floating point
  mode and exception block. Assumes a 32-bit classic Wishbone register bus
  with byte addresses and one register per aligned word.
*/
`default_nettype none

package fpu_pkg;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] OFS_MODE_STATUS = 8'h00;
  localparam logic [7:0] OFS_EXC_CODE = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_OPND_HI = 8'h0c;
  localparam logic [7:0] OFS_OPND_LO = 8'h10;
  localparam logic [7:0] OFS_RESULT_HI = 8'h14;
  localparam logic [7:0] OFS_RESULT_LO = 8'h18;
  localparam logic [7:0] OFS_UNIT_INFO = 8'h1c;

  // ==========================================================
  // mode/status bit positions and reset values
  localparam int BIT_ERR_FLAG = 15;
  localparam int BIT_ALL_INT_DIS = 14;
  localparam int BIT_UNDEF_VAR_EN = 11;
  localparam int BIT_UNDERFLOW_EN = 10;
  localparam int BIT_OVERFLOW_EN = 9;
  localparam int BIT_CONV_ERR_EN = 8;
  localparam int BIT_DOUBLE_MODE = 7;
  localparam int BIT_LONG_INT_MODE = 6;
  localparam int BIT_TRUNCATE_MODE = 5;
  localparam int BIT_MAINT_MODE = 4;
  localparam int BIT_NEG_FLAG = 3;
  localparam int BIT_ZERO_FLAG = 2;
  localparam int BIT_OVF_FLAG = 1;
  localparam int BIT_CARRY_FLAG = 0;
  localparam logic [15:0] STATUS_WR_MASK = 16'hcfff;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [3:0] EXC_CODE_RESET = 4'h0;

  // ==========================================================
  // exception codes, trap vector, format constants
  localparam logic [3:0] EXC_NONE = 4'h0;
  localparam logic [3:0] EXC_OPCODE = 4'h2;
  localparam logic [3:0] EXC_DIV_ZERO = 4'h4;
  localparam logic [3:0] EXC_INT_CONV = 4'h6;
  localparam logic [3:0] EXC_OVERFLOW = 4'h8;
  localparam logic [3:0] EXC_UNDERFLOW = 4'ha;
  localparam logic [3:0] EXC_UNDEF_VAR = 4'hc;
  localparam logic [3:0] EXC_MAINT = 4'he;
  localparam logic [7:0] TRAP_VECTOR = 8'hf4;
  localparam logic [7:0] EXP_BIAS = 8'h80;
  localparam logic [5:0] SHORT_INT_BITS = 6'h0f;
  localparam logic [5:0] LONG_INT_BITS = 6'h1f;
  localparam logic [3:0] STEP_SINGLE = 4'h4;
  localparam logic [3:0] STEP_DOUBLE = 4'h8;
  localparam logic [2:0] MODE_DIRECT_ACC = 3'h0;
  localparam logic [2:0] MODE_AUTO_INC = 3'h2;
  localparam logic [2:0] REG_PROG_COUNTER = 3'h7;
  localparam logic [2:0] NUM_MEM_ACC = 3'h4;

  // ==========================================================
  // operations
  localparam logic [2:0] OP_LOAD = 3'h0;
  localparam logic [2:0] OP_STORE = 3'h1;
  localparam logic [2:0] OP_NEGATE = 3'h2;
  localparam logic [2:0] OP_STORE_CONV_INT = 3'h3;
  localparam logic [2:0] OP_SCALE = 3'h4;
  localparam logic [2:0] OP_DBL_TO_SGL = 3'h5;

  typedef struct packed {
    logic [7:0] scale;
    logic [3:0] spare;
    logic [2:0] rn;
    logic [2:0] mode;
    logic [2:0] ac;
    logic [2:0] op;
  } fpu_cmd_t;

  typedef enum logic [0:0] {
    FPU_IDLE = 1'b0,
    FPU_EXEC = 1'b1
  } fpu_state_t;

endpackage : fpu_pkg

`default_nettype wire

// ===== hw/fpu_modes_core.sv
/*
  Floating point unit state: six 64-bit accumulators, the mode and status
  register, the exception code register and a one-cycle operation engine
  for load, store, negate, float-to-integer store, exponent scale and
  double-to-single conversion. Assumes a classic Wishbone master that
  holds each request until ack and a host that waits while the unit is busy.
*/
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - six 64-bit accumulators; single precision touches only the upper 32 bits
// - direct mode names any accumulator; memory modes only the first four
// - single values use 32 bits, double values 64 bits
// - exponent is 8 bits biased by 128
// - sign-magnitude fraction, hidden one, 23 or 55 stored bits
// - a zero exponent field means the value zero
// - rounding goes away from zero
// - status bit 6 picks 32-bit or 16-bit integers for conversion
// - status bit 15 flags an exception whose own enable was set
// - status bit 14 suppresses every floating interrupt
// - bit 11 traps on negative zero fetched from memory, else accepted
// - bit 10 traps underflow with wrapped exponent, else result is zero
// - bit 9 traps overflow; the result is the same either way
// - conversion carry writes zero to the destination; traps only with bit 8
// - status bit 7 selects double precision
// - status bit 5 selects truncation over rounding
// - status bit 4 selects maintenance mode instead of normal work
// - bits 3..0 hold negative, zero, overflow and conversion carry
// - every floating exception traps through vector 244
// - a trap loads the 4-bit exception code register
// - eight addressing modes; mode 0 names an accumulator
// - auto step is 4 for single and 8 for double operands
// - immediate mode moves only 16 bits
module fpu_modes_core
  import fpu_pkg::*;
#(
  parameter int NUM_ACC = 6
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic BUSY_OUT,
  output logic TRAP_OUT,
  output logic [7:0] TRAP_VECTOR_OUT
);

  // ==========================================================
  // state
  logic [63:0] acc_reg [NUM_ACC];
  logic [15:0] status_reg;
  logic [3:0] exc_code_reg;
  fpu_cmd_t cmd_reg;
  fpu_state_t state_reg;
  logic [31:0] opnd_hi_reg, opnd_lo_reg, res_hi_reg, res_lo_reg;
  logic ack_reg;

  // ==========================================================
  // bus decode
  logic wb_req, wb_wr;
  logic [31:0] wmask, rdata;
  assign wb_req = WB_CYC_IN && WB_STB_IN;
  // writes land on the edge at which the master samples ack
  assign wb_wr = wb_req && WB_WE_IN && ack_reg;
  assign wmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};

  // read mux; unmapped offsets read as zero
  always_comb
  begin
    rdata = 32'h0;
    if (WB_ADR_IN == OFS_MODE_STATUS)
      rdata = {16'h0, status_reg};
    else if (WB_ADR_IN == OFS_EXC_CODE)
      rdata = {28'h0, exc_code_reg};
    else if (WB_ADR_IN == OFS_COMMAND)
      rdata = {8'h0, cmd_reg};
    else if (WB_ADR_IN == OFS_OPND_HI)
      rdata = opnd_hi_reg;
    else if (WB_ADR_IN == OFS_OPND_LO)
      rdata = opnd_lo_reg;
    else if (WB_ADR_IN == OFS_RESULT_HI)
      rdata = res_hi_reg;
    else if (WB_ADR_IN == OFS_RESULT_LO)
      rdata = res_lo_reg;
    else if (WB_ADR_IN == OFS_UNIT_INFO)
      rdata = {20'h0, (status_reg[BIT_DOUBLE_MODE] ? STEP_DOUBLE : STEP_SINGLE), 7'h0,
               BUSY_OUT};
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      ack_reg <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end
    else
    begin
      ack_reg <= wb_req && !ack_reg;
      if (wb_req && !ack_reg)
        WB_DAT_OUT <= rdata;
    end
  end
  assign WB_ACK_OUT = ack_reg;

  // operand registers written by software
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      opnd_hi_reg <= 32'h0;
      opnd_lo_reg <= 32'h0;
    end
    else if (wb_wr && WB_ADR_IN == OFS_OPND_HI)
      opnd_hi_reg <= (opnd_hi_reg & ~wmask) | (WB_DAT_IN & wmask);
    else if (wb_wr && WB_ADR_IN == OFS_OPND_LO)
      opnd_lo_reg <= (opnd_lo_reg & ~wmask) | (WB_DAT_IN & wmask);
  end

  // ==========================================================
  // operation datapath
  logic dbl, ft, maint, is_mem, imm, ac_ok, rn_ok, neg_zero, src_dbl;
  logic [63:0] acc_a, acc_p, acc_r, src, value;
  logic [3:0] exc;
  logic exc_en, wr_acc, wr_single, wr_res, cc_we, new_v, new_c, uflow, oflow;
  logic [2:0] wr_idx;
  logic [63:0] res_data;
  logic [9:0] sum10;
  logic [31:0] rnd, m32, mag, intv;
  logic [8:0] texp;
  logic [5:0] lim;
  logic [15:0] st_next;

  always_comb
  begin
    dbl = status_reg[BIT_DOUBLE_MODE];
    ft = status_reg[BIT_TRUNCATE_MODE];
    maint = status_reg[BIT_MAINT_MODE];
    is_mem = cmd_reg.mode != MODE_DIRECT_ACC;
    imm = cmd_reg.mode == MODE_AUTO_INC && cmd_reg.rn == REG_PROG_COUNTER;
    ac_ok = 32'(cmd_reg.ac) < NUM_ACC;
    rn_ok = 32'(cmd_reg.rn) < NUM_ACC;
    acc_a = ac_ok ? acc_reg[cmd_reg.ac] : 64'h0;
    acc_r = rn_ok ? acc_reg[cmd_reg.rn] : 64'h0;
    acc_p = dbl ? acc_a : {acc_a[63:32], 32'h0};
    src_dbl = dbl || cmd_reg.op == OP_DBL_TO_SGL;
    // fetch the source operand by addressing mode
    if (!is_mem)
      src = src_dbl ? acc_r : {acc_r[63:32], 32'h0};
    else if (imm)
      src = {opnd_hi_reg[31:16], 48'h0};
    else
      src = {opnd_hi_reg, src_dbl ? opnd_lo_reg : 32'h0};
    neg_zero = is_mem && src[63] && src[62:55] == 8'h0;
    exc = EXC_NONE;
    wr_acc = 1'b0;
    wr_single = !dbl;
    wr_idx = cmd_reg.ac;
    wr_res = 1'b0;
    cc_we = 1'b0;
    new_v = 1'b0;
    new_c = 1'b0;
    uflow = 1'b0;
    oflow = 1'b0;
    value = 64'h0;
    sum10 = 10'h0;
    rnd = 32'h0;
    texp = 9'h0;
    lim = status_reg[BIT_LONG_INT_MODE] ? LONG_INT_BITS : SHORT_INT_BITS;
    m32 = {1'b1, acc_p[54:24]};
    mag = 32'h0;
    intv = 32'h0;
    if (maint)
      exc = EXC_MAINT;
    else if (!ac_ok || (is_mem && cmd_reg.ac >= NUM_MEM_ACC) || (!is_mem && !rn_ok)
             || cmd_reg.op > OP_DBL_TO_SGL)
      exc = EXC_OPCODE;
    else
    begin
      case (cmd_reg.op)
        OP_LOAD:
        begin
          if (neg_zero && status_reg[BIT_UNDEF_VAR_EN])
            exc = EXC_UNDEF_VAR;
          else
          begin
            value = (src[62:55] == 8'h0) ? 64'h0 : src;
            wr_acc = 1'b1;
            cc_we = 1'b1;
          end
        end
        OP_STORE:
        begin
          value = acc_p;
          wr_acc = !is_mem;
          wr_idx = cmd_reg.rn;
          wr_res = is_mem;
        end
        OP_NEGATE:
        begin
          if (neg_zero && status_reg[BIT_UNDEF_VAR_EN])
            exc = EXC_UNDEF_VAR;
          else
          begin
            value = (src[62:55] == 8'h0) ? 64'h0 : {~src[63], src[62:0]};
            wr_acc = !is_mem;
            wr_idx = cmd_reg.rn;
            wr_res = is_mem;
            cc_we = 1'b1;
          end
        end
        OP_STORE_CONV_INT:
        begin
          texp = {1'b0, acc_p[62:55]} - {1'b0, EXP_BIAS};
          if (acc_p[62:55] <= EXP_BIAS)
            mag = 32'h0; // below one, or zero
          else if (texp[5:0] > lim || texp[8:6] != 3'h0)
            new_c = 1'b1;
          else
            mag = m32 >> (6'h20 - texp[5:0]);
          intv = acc_p[63] ? (32'h0 - mag) : mag;
          if (!status_reg[BIT_LONG_INT_MODE])
            intv = {{16{intv[15]}}, intv[15:0]};
          if (new_c)
          begin
            intv = 32'h0;
            exc = EXC_INT_CONV;
          end
          value = {intv, 32'h0};
          wr_res = 1'b1;
          cc_we = 1'b1;
        end
        OP_SCALE:
        begin
          sum10 = {2'b00, acc_p[62:55]} + {{2{cmd_reg.scale[7]}}, cmd_reg.scale};
          if (acc_p[62:55] != 8'h0)
          begin
            oflow = !sum10[9] && sum10[8];
            uflow = sum10[9] || sum10 == 10'h0;
            // the exponent wraps modulo 256 when out of range
            value = {acc_p[63], sum10[7:0], acc_p[54:0]};
            if (uflow && !status_reg[BIT_UNDERFLOW_EN])
              value = 64'h0;
          end
          if (oflow)
            exc = EXC_OVERFLOW;
          else if (uflow)
            exc = EXC_UNDERFLOW;
          new_v = oflow;
          wr_acc = 1'b1;
          cc_we = 1'b1;
        end
        default:
        begin
          if (neg_zero && status_reg[BIT_UNDEF_VAR_EN])
            exc = EXC_UNDEF_VAR;
          else
          begin
            // round half away from zero unless truncating
            rnd = {1'b0, src[62:32]} + {31'h0, !ft && src[31]};
            oflow = rnd[31];
            value = (src[62:55] == 8'h0) ? 64'h0 : {src[63], rnd[30:0], 32'h0};
            exc = oflow ? EXC_OVERFLOW : EXC_NONE;
            new_v = oflow;
            wr_acc = 1'b1;
            wr_single = 1'b1;
            cc_we = 1'b1;
          end
        end
      endcase
    end
    // immediate stores move only the top 16 bits
    res_data = imm ? {value[63:48], 48'h0} : value;
    case (exc)
      EXC_UNDEF_VAR: exc_en = status_reg[BIT_UNDEF_VAR_EN];
      EXC_UNDERFLOW: exc_en = status_reg[BIT_UNDERFLOW_EN];
      EXC_OVERFLOW: exc_en = status_reg[BIT_OVERFLOW_EN];
      EXC_INT_CONV: exc_en = status_reg[BIT_CONV_ERR_EN];
      EXC_NONE: exc_en = 1'b0;
      default: exc_en = 1'b1;
    endcase
  end

  // ==========================================================
  // sequencer: a command is taken only while idle
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      state_reg <= FPU_IDLE;
      cmd_reg <= '0;
      BUSY_OUT <= 1'b0;
    end
    else
    begin
      case (state_reg)
        FPU_IDLE:
        begin
          // a command written while busy is dropped; the host must wait
          if (wb_wr && WB_ADR_IN == OFS_COMMAND)
          begin
            cmd_reg <= fpu_cmd_t'(WB_DAT_IN[23:0]);
            state_reg <= FPU_EXEC;
            BUSY_OUT <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= FPU_IDLE;
          BUSY_OUT <= 1'b0;
        end
      endcase
    end
  end

  // accumulator file
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < NUM_ACC; i++)
        acc_reg[i] <= 64'h0;
    end
    else if (state_reg == FPU_EXEC && wr_acc)
    begin
      if (wr_single)
        acc_reg[wr_idx][63:32] <= value[63:32];
      else
        acc_reg[wr_idx] <= value;
    end
  end

  // result registers seen by the host
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      res_hi_reg <= 32'h0;
      res_lo_reg <= 32'h0;
    end
    else if (state_reg == FPU_EXEC && wr_res)
    begin
      if (cmd_reg.op == OP_STORE_CONV_INT)
        res_lo_reg <= res_data[63:32];
      else
      begin
        res_hi_reg <= res_data[63:32];
        res_lo_reg <= (dbl && !imm) ? res_data[31:0] : 32'h0;
      end
    end
  end

  // mode/status and exception code; hardware set of the error flag wins
  always_comb
  begin
    st_next = status_reg;
    if (wb_wr && WB_ADR_IN == OFS_MODE_STATUS)
      st_next = (status_reg & ~(wmask[15:0] & STATUS_WR_MASK))
                | (WB_DAT_IN[15:0] & wmask[15:0] & STATUS_WR_MASK);
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      status_reg <= STATUS_RESET;
      exc_code_reg <= EXC_CODE_RESET;
      TRAP_OUT <= 1'b0;
      TRAP_VECTOR_OUT <= TRAP_VECTOR;
    end
    else
    begin
      status_reg <= st_next;
      TRAP_OUT <= 1'b0;
      TRAP_VECTOR_OUT <= TRAP_VECTOR;
      if (state_reg == FPU_EXEC)
      begin
        if (cc_we)
        begin
          status_reg[BIT_NEG_FLAG] <= value[63] && value[62:55] != 8'h0;
          status_reg[BIT_ZERO_FLAG] <= (cmd_reg.op == OP_STORE_CONV_INT) ?
                                       intv == 32'h0 : value[62:55] == 8'h0;
          status_reg[BIT_OVF_FLAG] <= new_v;
          status_reg[BIT_CARRY_FLAG] <= new_c;
          if (cmd_reg.op == OP_STORE_CONV_INT)
            status_reg[BIT_NEG_FLAG] <= intv[31];
        end
        if (exc_en)
        begin
          status_reg[BIT_ERR_FLAG] <= 1'b1;
          if (!status_reg[BIT_ALL_INT_DIS])
          begin
            TRAP_OUT <= 1'b1;
            exc_code_reg <= exc;
          end
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");
  single_keep_a: assert property ((state_reg == FPU_EXEC && wr_acc && wr_single) |=>
    acc_reg[$past(wr_idx)][31:0] == $past(acc_reg[wr_idx][31:0]))
    else $error("single precision write changed the low word");
  acc_restrict_a: assert property ((state_reg == FPU_EXEC && !maint && is_mem
    && cmd_reg.ac >= NUM_MEM_ACC) |-> exc == EXC_OPCODE && !wr_acc)
    else $error("memory mode used an upper accumulator");
  err_flag_a: assert property (TRAP_OUT |-> status_reg[BIT_ERR_FLAG])
    else $error("trap without error flag");
  int_disable_a: assert property ((state_reg == FPU_EXEC && status_reg[BIT_ALL_INT_DIS])
    |=> !TRAP_OUT)
    else $error("trap while all interrupts disabled");
  uflow_zero_a: assert property ((state_reg == FPU_EXEC && uflow
    && !status_reg[BIT_UNDERFLOW_EN]) |=> acc_reg[$past(wr_idx)][63:32] == 32'h0)
    else $error("silent underflow did not give zero");
  conv_zero_a: assert property ((state_reg == FPU_EXEC && cmd_reg.op == OP_STORE_CONV_INT
    && new_c && !maint && exc != EXC_OPCODE) |=> res_lo_reg == 32'h0
    && status_reg[BIT_CARRY_FLAG])
    else $error("conversion carry did not zero the destination");
  maint_trap_a: assert property ((state_reg == FPU_EXEC && maint
    && !status_reg[BIT_ALL_INT_DIS]) |=> TRAP_OUT && exc_code_reg == EXC_MAINT)
    else $error("maintenance mode did not trap");
  busy_span_a: assert property ($rose(BUSY_OUT) |=> !BUSY_OUT [*2])
    else $error("busy longer than one cycle");
  reset_clear_a: assert property (@(posedge SYS_CLK_IN) disable iff (1'b0)
    RST_IN |=> status_reg == STATUS_RESET && exc_code_reg == EXC_CODE_RESET)
    else $error("reset left status or code set");

  trap_seen_c: cover property (TRAP_OUT);
  conv_ok_c: cover property (state_reg == FPU_EXEC && cmd_reg.op == OP_STORE_CONV_INT && !new_c);
  round_up_c: cover property (state_reg == FPU_EXEC && cmd_reg.op == OP_DBL_TO_SGL && src[31]);
  uflow_trap_c: cover property (state_reg == FPU_EXEC && uflow && exc_en);

endmodule : fpu_modes_core

`default_nettype wire

// ===== tb/fpu_host_model.sv
/*
  host side model: a classic wishbone master with a command helper.
  assumes a unit that acks every request and raises busy per command.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// host model
module fpu_host_model
  import fpu_pkg::*;
(
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic busy_in,
  input wire logic trap_in,
  input wire logic [31:0] dat_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [7:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out
);
  // idle bus from time zero
  initial
  begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'hf;
    dat_out = 32'h0;
  end

  // one cycle; released lines show the inverse so stale data is not reused
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    dat_out <= d;
    do
      @(posedge clk_in);
    while (ack_in !== 1'b1);
    q = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    adr_out <= ~a;
    dat_out <= ~d;
  endtask : xfer

  // command write paced by busy; returns the trap seen after execution
  task automatic run(input logic [31:0] c, output logic t);
    logic [31:0] q;
    while (busy_in !== 1'b0)
      @(posedge clk_in);
    xfer(1'b1, OFS_COMMAND, c, q);
    do
      @(posedge clk_in);
    while (busy_in !== 1'b1);
    @(posedge clk_in);
    t = trap_in;
  endtask : run
endmodule : fpu_host_model

`default_nettype wire

// ===== tb/testbench.sv
/*
  self-checking bench for the float mode and exception block.
  assumes the host model on the register bus and a 25 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) \
  begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

// ==========================================================
// top
module testbench
  import fpu_pkg::*;
;
  logic clk, rst, cyc, stb, we, ack, busy, trap;
  logic [7:0] adr, vec;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [31:0] LD0 = 32'h40;
  localparam logic [31:0] ST0 = 32'h41;
  // float-to-integer store of ac0 into the result low word
  localparam logic [31:0] CVT = 32'h43;
  localparam logic [31:0] BAD [4] = '{32'h60, 32'h6, 32'h30, 32'hc00};

  fpu_modes_core dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .BUSY_OUT(busy),
    .TRAP_OUT(trap), .TRAP_VECTOR_OUT(vec));
  fpu_host_model host_u (.clk_in(clk), .ack_in(ack), .busy_in(busy),
    .trap_in(trap), .dat_in(rdat), .cyc_out(cyc), .stb_out(stb), .we_out(we),
    .adr_out(adr), .sel_out(sel), .dat_out(wdat));

  function automatic logic [31:0] c(logic [2:0] op, ac, md, rn, logic [7:0] sc);
    fpu_cmd_t k;
    k = '{scale: sc, spare: 4'h0, rn: rn, mode: md, ac: ac, op: op};
    return {8'h00, k};
  endfunction : c

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host_u.xfer(1'b0, a, 32'h0, q);
    `CHK($sformatf("reg %h", a), e, q)
  endtask : rd

  task automatic op(input logic [31:0] k, input logic t);
    logic g;
    host_u.run(k, g);
    `CHK("trap", t, g)
  endtask : op

  // status, operands, load ac0, the operation, store ac0, result word
  task automatic chain(input logic [15:0] s, input logic [31:0] hi, lo, k,
    input logic t, input logic [31:0] r);
    wr(OFS_MODE_STATUS, {16'h0, s});
    wr(OFS_OPND_HI, hi);
    wr(OFS_OPND_LO, lo);
    op(LD0, 1'b0);
    op(k, t);
    op(ST0, 1'b0);
    rd(OFS_RESULT_HI, r);
  endtask : chain

  // clock; a hang is cut short well above the expected few hundred cycles
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_MODE_STATUS, 32'h0);
    rd(OFS_EXC_CODE, 32'h0);
    `CHK("vector", 8'hf4, vec)
    rd(8'h40, 32'h0);
    rd(OFS_UNIT_INFO, 32'h400);
    wr(OFS_MODE_STATUS, 32'hffff);
    rd(OFS_MODE_STATUS, 32'hcfff);
    // double load, then a single load must keep the low word
    wr(OFS_MODE_STATUS, 32'h0080);
    rd(OFS_UNIT_INFO, 32'h800);
    wr(OFS_OPND_HI, 32'h40c00000);
    wr(OFS_OPND_LO, 32'h12345678);
    op(c(OP_LOAD, 3'h1, 3'h1, 3'h0, 8'h0), 1'b0);
    wr(OFS_MODE_STATUS, 32'h0);
    wr(OFS_OPND_HI, 32'h41200000);
    wr(OFS_OPND_LO, 32'hdeadbeef);
    op(c(OP_LOAD, 3'h1, 3'h1, 3'h0, 8'h0), 1'b0);
    wr(OFS_MODE_STATUS, 32'h0080);
    op(c(OP_STORE, 3'h1, 3'h1, 3'h0, 8'h0), 1'b0);
    rd(OFS_RESULT_HI, 32'h41200000);
    rd(OFS_RESULT_LO, 32'h12345678);
    op(c(OP_STORE, 3'h1, 3'h0, 3'h5, 8'h0), 1'b0);
    op(c(OP_LOAD, 3'h0, 3'h0, 3'h5, 8'h0), 1'b0);
    op(ST0, 1'b0);
    rd(OFS_RESULT_LO, 32'h12345678);
    // formats, flags, rounding and immediate operands
    chain(16'h0, 32'h00400000, 32'h0, LD0, 1'b0, 32'h0);
    rd(OFS_MODE_STATUS, 32'h0004);
    chain(16'h0, 32'hc1200000, 32'h0, LD0, 1'b0, 32'hc1200000);
    rd(OFS_MODE_STATUS, 32'h0008);
    chain(16'h0, 32'h41200000, 32'h0, c(OP_NEGATE, 3'h0, 3'h0, 3'h0, 8'h0), 1'b0,
      32'hc1200000);
    rd(OFS_MODE_STATUS, 32'h0008);
    chain(16'h0, 32'h40800000, 32'h80000000, c(OP_DBL_TO_SGL, 3'h0, 3'h1, 3'h0,
      8'h0), 1'b0, 32'h40800001);
    chain(16'h0020, 32'h40800000, 32'h80000000, c(OP_DBL_TO_SGL, 3'h0, 3'h1,
      3'h0, 8'h0), 1'b0, 32'h40800000);
    chain(16'h0, 32'h41234567, 32'h0, c(OP_LOAD, 3'h0, 3'h2, 3'h7, 8'h0), 1'b0,
      32'h41230000);
    // exponent wrap on overflow, enabled and not, and on enabled underflow; silent underflow gives zero
    chain(16'h0200, 32'h7f000000, 32'h0, c(OP_SCALE, 3'h0, 3'h1, 3'h0, 8'h03),
      1'b1, 32'h00800000);
    rd(OFS_EXC_CODE, 32'h8);
    chain(16'h0, 32'h7f000000, 32'h0, c(OP_SCALE, 3'h0, 3'h1, 3'h0, 8'h03),
      1'b0, 32'h00800000);
    rd(OFS_MODE_STATUS, 32'h0002);
    chain(16'h0400, 32'h01000000, 32'h0, c(OP_SCALE, 3'h0, 3'h1, 3'h0, 8'hfd),
      1'b1, 32'h7f800000);
    rd(OFS_EXC_CODE, 32'ha);
    chain(16'h0, 32'h01000000, 32'h0, c(OP_SCALE, 3'h0, 3'h1, 3'h0, 8'hfd),
      1'b0, 32'h0);
    // float to integer in short and long widths; the store in chain clears
    // the low result word, so each conversion is run again before reading it
    chain(16'h0040, 32'h4a800000, 32'h0, CVT, 1'b0, 32'h4a800000);
    op(CVT, 1'b0);
    rd(OFS_RESULT_LO, 32'h00100000);
    wr(OFS_MODE_STATUS, 32'h0100);
    op(CVT, 1'b1);
    rd(OFS_RESULT_LO, 32'h0);
    rd(OFS_EXC_CODE, 32'h6);
    chain(16'h0100, 32'h4a800000, 32'h0, CVT, 1'b1, 32'h4a800000);
    chain(16'h0, 32'h4a800000, 32'h0, CVT, 1'b0, 32'h4a800000);
    chain(16'h0, 32'h45800000, 32'h0, CVT, 1'b0, 32'h45800000);
    op(CVT, 1'b0);
    rd(OFS_RESULT_LO, 32'h00000400);
    // negative zero fetched from memory
    wr(OFS_MODE_STATUS, 32'h0800);
    wr(OFS_OPND_HI, 32'h80000000);
    op(LD0, 1'b1);
    rd(OFS_EXC_CODE, 32'hc);
    rd(OFS_MODE_STATUS, 32'h8800);
    chain(16'h0, 32'h80000000, 32'h0, LD0, 1'b0, 32'h0);
    // illegal encodings, global disable, maintenance
    foreach (BAD[i])
    begin
      wr(OFS_MODE_STATUS, 32'h0);
      op(BAD[i], 1'b1);
      rd(OFS_EXC_CODE, 32'h2);
    end
    wr(OFS_MODE_STATUS, 32'h4010);
    op(LD0, 1'b0);
    rd(OFS_EXC_CODE, 32'h2);
    rd(OFS_MODE_STATUS, 32'hc010);
    wr(OFS_MODE_STATUS, 32'h0010);
    op(LD0, 1'b1);
    rd(OFS_EXC_CODE, 32'he);
    conclude();
  end
endmodule : testbench

`default_nettype wire
